// ===== temp_conversion_alarm_core.sv
// Temperature conversion, scratchpad view and alarm flag of the thermometer
`default_nettype none

module temp_conversion_alarm_core #(
    parameter int          CONV_CYCLES = temp_alarm_pkg::CONV_CYCLES,
    parameter logic [63:0] ROM_ID      = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      cmd_valid_i,
    input  wire logic [7:0]                cmd_code_i,
    input  wire logic                      read_slot_i,
    input  wire logic                      ext_power_i,
    input  wire logic signed [8:0]         sensor_half_deg_i,
    input  wire logic [7:0]                sensor_remain_i,
    input  wire temp_alarm_pkg::sp_req_type sp_req_i,
    input  wire logic                      dq_in_i,
    output logic [7:0]                     sp_rdata_o,
    output logic                           sp_rvalid_o,
    output logic [15:0]                    temp_o,
    output logic                           busy_o,
    output logic                           alarm_flag_o,
    output logic                           search_member_o,
    output logic [63:0]                    rom_id_o,
    output logic                           dq_out_o,
    output logic                           dq_oe_n_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic alarm_of(input logic [15:0] t,
                                      input logic [7:0]  hi,
                                      input logic [7:0]  lo);
        logic signed [7:0] v;
        v = signed'(t[8:1]);
        return (v <= signed'(lo)) || (v > signed'(hi));
    endfunction

    localparam logic [temp_alarm_pkg::CONV_CNT_W-1:0] CNT_LAST =
        temp_alarm_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

    // ------------------------------------------------------------
    // Conversion state
    // ------------------------------------------------------------
    temp_alarm_pkg::conv_state_type                state_r, state_nxt;
    logic [temp_alarm_pkg::CONV_CNT_W-1:0]         cnt_r, cnt_nxt;
    logic [15:0]                                   temp_r, temp_nxt;
    logic [7:0]                                    remain_r, remain_nxt;
    logic                                          alarm_r, alarm_nxt;
    logic                                          member_r, member_nxt;
    logic                                          polling_r, polling_nxt;
    // Limits reload from the nonvolatile init values at power-up
    logic [7:0]                                    upper_r, upper_nxt;
    logic [7:0]                                    lower_r, lower_nxt;
    logic                                          done;
    logic                                          is_convert;

    assign is_convert = cmd_valid_i && (cmd_code_i == temp_alarm_pkg::CMD_CONVERT);
    assign done       = (state_r == temp_alarm_pkg::ST_CONVERT) && (cnt_r == CNT_LAST);

    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        temp_nxt    = temp_r;
        remain_nxt  = remain_r;
        alarm_nxt   = alarm_r;
        member_nxt  = member_r;
        polling_nxt = polling_r;
        unique case (state_r)
            temp_alarm_pkg::ST_IDLE: begin
                if (is_convert) begin
                    state_nxt   = temp_alarm_pkg::ST_CONVERT;
                    cnt_nxt     = '0;
                    polling_nxt = 1'b1;
                end
            end
            temp_alarm_pkg::ST_CONVERT: begin
                if (done) begin
                    // Half-degree steps, sign copied through the high byte
                    temp_nxt   = {{7{sensor_half_deg_i[8]}}, sensor_half_deg_i};
                    remain_nxt = sensor_remain_i;
                    alarm_nxt  = alarm_of({{7{sensor_half_deg_i[8]}}, sensor_half_deg_i},
                                          upper_r, lower_r);
                    state_nxt  = temp_alarm_pkg::ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        endcase
        // Any other command ends the status-polling window
        if (cmd_valid_i && !is_convert) begin
            polling_nxt = 1'b0;
        end
        if (cmd_valid_i && (cmd_code_i == temp_alarm_pkg::CMD_ALARM_SEARCH)) begin
            member_nxt = alarm_r;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r   <= temp_alarm_pkg::ST_IDLE;
            cnt_r     <= '0;
            temp_r    <= temp_alarm_pkg::TEMP_RESET;
            remain_r  <= '0;
            alarm_r   <= 1'b0;
            member_r  <= 1'b0;
            polling_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            temp_r    <= temp_nxt;
            remain_r  <= remain_nxt;
            alarm_r   <= alarm_nxt;
            member_r  <= member_nxt;
            polling_r <= polling_nxt;
        end
    end

    // ------------------------------------------------------------
    // Scratchpad: limits and read port
    // ------------------------------------------------------------
    logic [7:0] rdata_r, rdata_nxt;
    logic       rvalid_r, rvalid_nxt;

    always_comb begin
        upper_nxt  = upper_r;
        lower_nxt  = lower_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        if (sp_req_i.valid && sp_req_i.write) begin
            // Bytes 0/1 and the fixed bytes ignore writes
            if (sp_req_i.addr == temp_alarm_pkg::SP_UPPER_LIMIT) begin
                upper_nxt = sp_req_i.data;
            end
            if (sp_req_i.addr == temp_alarm_pkg::SP_LOWER_LIMIT) begin
                lower_nxt = sp_req_i.data;
            end
        end
        if (sp_req_i.valid && !sp_req_i.write) begin
            rvalid_nxt = 1'b1;
            unique case (sp_req_i.addr)
                temp_alarm_pkg::SP_TEMP_LSB:     rdata_nxt = temp_r[7:0];
                temp_alarm_pkg::SP_TEMP_MSB:     rdata_nxt = temp_r[15:8];
                temp_alarm_pkg::SP_UPPER_LIMIT:  rdata_nxt = upper_r;
                temp_alarm_pkg::SP_LOWER_LIMIT:  rdata_nxt = lower_r;
                temp_alarm_pkg::SP_RESERVED_A,
                temp_alarm_pkg::SP_RESERVED_B:   rdata_nxt = temp_alarm_pkg::RESERVED_VALUE;
                temp_alarm_pkg::SP_COUNT_REMAIN: rdata_nxt = remain_r;
                temp_alarm_pkg::SP_COUNTS_PER_C: rdata_nxt = temp_alarm_pkg::COUNTS_PER_DEGREE;
                default:                         rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            upper_r  <= temp_alarm_pkg::UPPER_LIMIT_INIT;
            lower_r  <= temp_alarm_pkg::LOWER_LIMIT_INIT;
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else begin
            upper_r  <= upper_nxt;
            lower_r  <= lower_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data pin: open-drain status answer
    // ------------------------------------------------------------
    // Only externally powered parts answer; a parasite part must stay off the
    // line so the master's strong pullup can carry the conversion current.
    logic dq_oe_n_r, dq_oe_n_nxt;

    always_comb begin
        dq_oe_n_nxt = 1'b1;
        if (read_slot_i && dq_in_i && ext_power_i && polling_r &&
            (state_r == temp_alarm_pkg::ST_CONVERT)) begin
            dq_oe_n_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dq_oe_n_r <= 1'b1;
        end else begin
            dq_oe_n_r <= dq_oe_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [63:0] rom_id_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rom_id_r <= ROM_ID;
        end else begin
            rom_id_r <= rom_id_r;
        end
    end

    assign sp_rdata_o      = rdata_r;
    assign sp_rvalid_o     = rvalid_r;
    assign temp_o          = temp_r;
    assign busy_o          = (state_r == temp_alarm_pkg::ST_CONVERT);
    assign alarm_flag_o    = alarm_r;
    assign search_member_o = member_r;
    assign rom_id_o        = rom_id_r;
    assign dq_out_o        = 1'b0;
    assign dq_oe_n_o       = dq_oe_n_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_start;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!busy_o && is_convert) |=> busy_o;
    endproperty
    a_start: assert property (p_start) else $error("convert command did not start");

    property p_stay_idle;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!busy_o && !is_convert) |=> !busy_o;
    endproperty
    a_stay_idle: assert property (p_stay_idle) else $error("conversion without command");

    property p_done;
        @(posedge clk_i) disable iff (!reset_n_i)
        done |=> !busy_o && (temp_o[8:0] == $past(sensor_half_deg_i));
    endproperty
    a_done: assert property (p_done) else $error("result not stored at completion");

    property p_sign;
        @(posedge clk_i) disable iff (!reset_n_i)
        (temp_o[15:8] == {8{temp_o[8]}});
    endproperty
    a_sign: assert property (p_sign) else $error("temperature not sign-extended");

    property p_status_busy;
        @(posedge clk_i) disable iff (!reset_n_i)
        (read_slot_i && dq_in_i && ext_power_i && polling_r && busy_o) |=> !dq_oe_n_o;
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("busy slot not answered 0");

    property p_status_free;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!busy_o || !ext_power_i) |=> dq_oe_n_o;
    endproperty
    a_status_free: assert property (p_status_free) else $error("pin pulled when not busy");

    property p_cpd;
        @(posedge clk_i) disable iff (!reset_n_i)
        (sp_req_i.valid && !sp_req_i.write && sp_req_i.addr == temp_alarm_pkg::SP_COUNTS_PER_C)
        |=> (sp_rdata_o == temp_alarm_pkg::COUNTS_PER_DEGREE);
    endproperty
    a_cpd: assert property (p_cpd) else $error("counts-per-degree not sixteen");

    property p_alarm;
        @(posedge clk_i) disable iff (!reset_n_i)
        done |=> (alarm_flag_o == alarm_of(temp_o, $past(upper_r), $past(lower_r)));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm flag wrong after conversion");

    property p_alarm_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        !done |=> $stable(alarm_flag_o);
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm changed mid-idle");

    property p_search;
        @(posedge clk_i) disable iff (!reset_n_i)
        (cmd_valid_i && cmd_code_i == temp_alarm_pkg::CMD_ALARM_SEARCH)
        |=> (search_member_o == $past(alarm_flag_o));
    endproperty
    a_search: assert property (p_search) else $error("search membership wrong");

    property p_read_only;
        @(posedge clk_i) disable iff (!reset_n_i)
        (sp_req_i.valid && sp_req_i.write && !done) |=> $stable(temp_o);
    endproperty
    a_read_only: assert property (p_read_only) else $error("temperature byte was written");

    property p_open_drain;
        @(posedge clk_i) disable iff (!reset_n_i)
        !dq_oe_n_o |-> (dq_out_o == 1'b0);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_count_bound;
        @(posedge clk_i) disable iff (!reset_n_i)
        busy_o |-> (cnt_r <= CNT_LAST);
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("conversion counter overran");

    property p_rvalid_pulse;
        @(posedge clk_i) disable iff (!reset_n_i)
        !(sp_req_i.valid && !sp_req_i.write) |=> !sp_rvalid_o;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

endmodule // temp_conversion_alarm_core

`default_nettype wire

// ===== temp_alarm_pkg.sv
// Constants and carrier types shared by the conversion and alarm core
`default_nettype none

package temp_alarm_pkg;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CONVERT      = 8'h44;
    localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;

    // ------------------------------------------------------------
    // Scratchpad byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] SP_TEMP_LSB     = 4'h0;
    localparam logic [3:0] SP_TEMP_MSB     = 4'h1;
    localparam logic [3:0] SP_UPPER_LIMIT  = 4'h2;
    localparam logic [3:0] SP_LOWER_LIMIT  = 4'h3;
    localparam logic [3:0] SP_RESERVED_A   = 4'h4;
    localparam logic [3:0] SP_RESERVED_B   = 4'h5;
    localparam logic [3:0] SP_COUNT_REMAIN = 4'h6;
    localparam logic [3:0] SP_COUNTS_PER_C = 4'h7;

    // ------------------------------------------------------------
    // Values after reset and fixed read values
    // ------------------------------------------------------------
    localparam logic [15:0] TEMP_RESET        = 16'h00aa;
    localparam logic [7:0]  COUNTS_PER_DEGREE = 8'h10;
    localparam logic [7:0]  RESERVED_VALUE    = 8'hff;
    localparam logic [7:0]  UPPER_LIMIT_INIT  = 8'h7f;
    localparam logic [7:0]  LOWER_LIMIT_INIT  = 8'h80;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ      = 200000;
    localparam int CONV_TIME_MS = 750;
    localparam int CONV_CYCLES  = CONV_TIME_MS * CLK_KHZ;
    localparam int CONV_CNT_W   = 28;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] addr;
        logic [7:0] data;
    } sp_req_type;

endpackage

`default_nettype wire

// ===== line_pullup_model.sv
// Shared data line with weak and strong pullup, seen from the master side
`default_nettype none

module line_pullup_model (
    input  wire logic dev_out_i,
    input  wire logic dev_oe_n_i,
    input  wire logic strong_pu_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Parties only pull low; the weak pullup makes the high level
    // Master's strong pullup keeps the line high through a parasite conversion
    always_comb begin
        if (strong_pu_i) begin
            line_o = 1'b1;
        end else begin
            line_o = dev_oe_n_i | dev_out_i;
        end
    end
endmodule // line_pullup_model

`default_nettype wire

// ===== temp_conversion_alarm_core_tb.sv
// Self-checking bench for the conversion and alarm core
`default_nettype none

module temp_conversion_alarm_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          CONV = 20;
    localparam logic [63:0] ID   = 64'h5a5a_0f0f_1234_8765; // Arbitrary value

    logic                       clk_i = 1'b0;
    logic                       reset_n_i;
    logic                       cmd_valid_i;
    logic [7:0]                 cmd_code_i;
    logic                       read_slot_i;
    logic                       ext_power_i;
    logic signed [8:0]          sensor_half_deg_i;
    logic [7:0]                 sensor_remain_i;
    temp_alarm_pkg::sp_req_type sp_req_i;
    logic                       dq_in_i;
    logic [7:0]                 sp_rdata_o;
    logic                       sp_rvalid_o;
    logic [15:0]                temp_o;
    logic                       busy_o;
    logic                       alarm_flag_o;
    logic                       search_member_o;
    logic [63:0]                rom_id_o;
    logic                       dq_out_o;
    logic                       dq_oe_n_o;
    logic                       strong_pu;
    int                         error_cnt = 0;
    int                         compares  = 0;
    int                         cyc       = 0;
    // Limits used below: upper 25.0, lower -10.0
    logic [8:0] tv [6] = '{9'h032, 9'h034, 9'h1ce, 9'h1ec, 9'h1ee, 9'h033};
    logic       ta [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    always #2.5 clk_i = ~clk_i;

    temp_conversion_alarm_core #(.CONV_CYCLES(CONV), .ROM_ID(ID)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_code_i(cmd_code_i), .read_slot_i(read_slot_i), .ext_power_i(ext_power_i),
        .sensor_half_deg_i(sensor_half_deg_i), .sensor_remain_i(sensor_remain_i),
        .sp_req_i(sp_req_i), .dq_in_i(dq_in_i), .sp_rdata_o(sp_rdata_o),
        .sp_rvalid_o(sp_rvalid_o), .temp_o(temp_o), .busy_o(busy_o),
        .alarm_flag_o(alarm_flag_o), .search_member_o(search_member_o),
        .rom_id_o(rom_id_o), .dq_out_o(dq_out_o), .dq_oe_n_o(dq_oe_n_o));

    line_pullup_model master_side (
        .dev_out_i(dq_out_o), .dev_oe_n_i(dq_oe_n_o), .strong_pu_i(strong_pu),
        .line_o(dq_in_i));

    // ------------------------------------------------------------
    // Shared tasks: cmd, sp_wr, sp_rd and conv start and end on a falling edge
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] code);
        cmd_valid_i = 1'b1;
        cmd_code_i  = code;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic sp_wr(input logic [3:0] a, input logic [7:0] d);
        sp_req_i = '{valid: 1'b1, write: 1'b1, addr: a, data: d};
        @(negedge clk_i);
        sp_req_i.valid = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic sp_rd(input logic [3:0] a, input logic [7:0] exp);
        sp_req_i = '{valid: 1'b1, write: 1'b0, addr: a, data: 8'h00};
        @(negedge clk_i);
        sp_req_i.valid = 1'b0;
        chk({63'h0, sp_rvalid_o}, 64'h1);
        chk({56'h0, sp_rdata_o}, {56'h0, exp});
        @(negedge clk_i);
    endtask

    // One conversion; polls once mid-way when powered, may re-issue 44h while busy
    task automatic conv(input logic [8:0] s, input logic ext, input logic again);
        int n;
        n = 0;
        ext_power_i       = ext;
        sensor_half_deg_i = s;
        strong_pu         = ~ext;
        cmd(8'h44);
        while (busy_o === 1'b1 && n < 1000) begin
            cmd_valid_i = again && (n == 5);
            read_slot_i = ext && (n == 3);
            if (ext && n == 4) begin
                chk({63'h0, dq_oe_n_o}, 64'h0);
                chk({63'h0, dq_in_i}, 64'h0);
            end
            n++;
            @(negedge clk_i);
        end
        strong_pu = 1'b0;
        // The command task has already spent the first busy cycle
        chk(n + 1, CONV);
        chk({48'h0, temp_o}, {48'h0, {7{s[8]}}, s});
        read_slot_i = 1'b1;
        @(negedge clk_i);
        read_slot_i = 1'b0;
        chk({63'h0, dq_oe_n_o}, 64'h1);
        @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({48'h0, temp_o}, 64'h00aa);
        chk({62'h0, busy_o, alarm_flag_o}, 64'h0);
        chk({63'h0, dq_oe_n_o}, 64'h1);
        chk(rom_id_o, ID);
        sp_rd(4'h0, 8'haa);
        sp_rd(4'h1, 8'h00);
        sp_rd(4'h7, 8'h10);
        sp_rd(4'h4, 8'hff);
        sp_rd(4'h8, 8'h00);
        $display("Test reset values finished");
    endtask

    task automatic t_limits();
        sp_wr(4'h2, 8'h19);
        sp_wr(4'h3, 8'hf6);
        sp_wr(4'h0, 8'h55);
        sp_wr(4'h7, 8'h00);
        sp_rd(4'h2, 8'h19);
        sp_rd(4'h3, 8'hf6);
        sp_rd(4'h0, 8'haa);
        sp_rd(4'h7, 8'h10);
        $display("Test limit access finished");
    endtask

    task automatic t_convert();
        conv(9'h1ce, 1'b1, 1'b0);
        sp_rd(4'h0, 8'hce);
        sp_rd(4'h1, 8'hff);
        // Truncated reading as the master forms it, half-degree bit dropped
        chk({56'h0, temp_o[8:1]}, 64'h00e7);
        sp_rd(4'h6, 8'h0c);
        sp_rd(4'h7, 8'h10);
        $display("Test negative conversion finished");
    endtask

    // Equal-to-upper, equal-to-lower and half-degree cases hit the compare edges
    task automatic t_alarm();
        for (int i = 0; i < 6; i++) begin
            conv(tv[i], 1'b1, 1'b0);
            chk({63'h0, alarm_flag_o}, {63'h0, ta[i]});
            cmd(8'hec);
            chk({63'h0, search_member_o}, {63'h0, ta[i]});
        end
        $display("Test alarm compare finished");
    endtask

    task automatic t_parasite();
        conv(9'h034, 1'b1, 1'b0);
        conv(9'h1ee, 1'b0, 1'b1);
        chk({63'h0, alarm_flag_o}, 64'h0);
        $display("Test parasite conversion finished");
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        reset_n_i         = 1'b0;
        cmd_valid_i       = 1'b0;
        cmd_code_i        = 8'h00;
        read_slot_i       = 1'b0;
        ext_power_i       = 1'b1;
        sensor_half_deg_i = 9'h000;
        sensor_remain_i   = 8'h0c;
        sp_req_i          = '0;
        strong_pu         = 1'b0;
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        @(negedge clk_i);
        t_reset();
        t_limits();
        t_convert();
        t_alarm();
        t_parasite();
        end_of_test();
    end
endmodule // temp_conversion_alarm_core_tb

`default_nettype wire
